// [include/tks_consts.svh]
// Register map, field layout, reset values and timing counts of the touch-key scanner
`ifndef TKS_CONSTS_SVH
`define TKS_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TKS_OFF_TRIGGER 6'h00
`define TKS_OFF_CFG_A 6'h04
`define TKS_OFF_CFG_B 6'h08
`define TKS_OFF_CHAN 6'h0C
`define TKS_OFF_IRQ 6'h10
`define TKS_OFF_ANA 6'h14
`define TKS_OFF_PIN_LO 6'h18
`define TKS_OFF_PIN_HI 6'h1C
`define TKS_OFF_PULLUP 6'h20
`define TKS_OFF_RESULT 6'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TKS_GO_BIT 0
`define TKS_SW_OFF_BIT 6
`define TKS_PAR_BIT 6
`define TKS_IRQ_EN_BIT 0
`define TKS_IRQ_STAT_BIT 1
`define TKS_IRQ_CLR_BIT 2
`define TKS_PREDIS_BIT 0
`define TKS_PRECHG_BIT 1
`define TKS_DS_LSB 2
`define TKS_WIDTH_LSB 4
`define TKS_VTH_LSB 0
`define TKS_RES_LSB 4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TKS_CFG_A_RST 7'h00
`define TKS_CFG_B_RST 7'h70
`define TKS_CHAN_RST 7'h00
`define TKS_ANA_RST 6'h20
`define TKS_PULLUP_RST 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define TKS_CLK_MHZ 25
`define TKS_PREDIS_SHORT_US 2
`define TKS_PREDIS_LONG_US 10
`define TKS_PRECHG_SHORT_US 20
`define TKS_PRECHG_LONG_US 40
`define TKS_PREDIS_SHORT_CYC (`TKS_PREDIS_SHORT_US * `TKS_CLK_MHZ)
`define TKS_PREDIS_LONG_CYC (`TKS_PREDIS_LONG_US * `TKS_CLK_MHZ)
`define TKS_PRECHG_SHORT_CYC (`TKS_PRECHG_SHORT_US * `TKS_CLK_MHZ)
`define TKS_PRECHG_LONG_CYC (`TKS_PRECHG_LONG_US * `TKS_CLK_MHZ)
`define TKS_WIDTH_BASE 9
`define TKS_DIV_BASE 4
`define TKS_DIV_NORMAL 6'h3E
`define TKS_DIV_UNIFORM 6'h3F
`define TKS_RAND_MIN_HALF 8
`define TKS_PULLUP_TOP 9'h1FF
`endif

// [include/tks_pkg.sv]
// Types shared by the touch-key scanner modules
package tks_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_PRE_DIS, ST_PRE_CHG, ST_COUNT, ST_DONE} tks_state_t;
   // Analog front-end controls, all registered
   typedef struct packed {
      logic sw_clk;
      logic discharge;
      logic precharge;
      logic parallel;
      logic [5:0] chan;
      logic [8:0] pullup_half_ua;
      logic [1:0] res_sel;
      logic [2:0] threshold_level_sel;
   } tks_afe_t;
endpackage : tks_pkg

// [design/tks_charge_clk.sv]
// Charge-discharge clock generator: fixed divider or pseudo-random spread
`include "tks_consts.svh"
module tks_charge_clk
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [5:0] div_code,
   // Clock out
   output logic sw_clk,
   output logic sw_edge
);
   // Seven bits: the slowest fixed code needs a half period of 65 ticks
   logic [6:0] half_cnt;
   logic [6:0] half_len;
   logic [15:0] lfsr;
   logic rand_mode;

   assign rand_mode = (div_code == `TKS_DIV_NORMAL) || (div_code == `TKS_DIV_UNIFORM);

   // Half period: fixed code+4 ticks, or random 8..23 ticks around the mid rate
   always_comb
   begin
      if (div_code == `TKS_DIV_UNIFORM)
         half_len = 7'(`TKS_RAND_MIN_HALF) + {3'h0, lfsr[3:0]};
      else if (div_code == `TKS_DIV_NORMAL)
         half_len = 7'(`TKS_RAND_MIN_HALF) + {4'h0, lfsr[2:0]} + {4'h0, lfsr[6:4]}; // Peaks mid
      else
         half_len = {1'b0, div_code} + 7'(`TKS_DIV_BASE);
   end

   // Reset-seeded LFSR; only advances on edges so the pattern stays per period
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         lfsr <= 16'hACE1;
      else if (sw_edge)
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end

   // Half-period counter and output toggle
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || !run)
      begin
         half_cnt <= 7'h00;
         sw_clk <= 1'b0;
      end
      else if (half_cnt + 7'h01 >= half_len)
      begin
         half_cnt <= 7'h00;
         sw_clk <= ~sw_clk;
      end
      else
         half_cnt <= half_cnt + 7'h01;
   end

   assign sw_edge = run && (half_cnt + 7'h01 >= half_len);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   fixed_spacing_a: assert property (sw_edge && !rand_mode && run |=> !sw_edge[*3])
      else $error("charge clock edge too soon");
   rand_spacing_a: assert property (sw_edge && rand_mode && run |=> !sw_edge[*7])
      else $error("random charge clock edge too soon");
   spread_run_c: cover property (rand_mode && sw_edge);
endmodule : tks_charge_clk

// [design/tks_scanner.sv]
// Touch-key scan controller: registers, scan sequencer and counter
`include "tks_consts.svh"
module tks_scanner
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   // System controls from other blocks
   input wire logic touch_clock_gate,
   input wire logic touch_power_down,
   // Analog front end
   input wire logic pad_cmp,
   output tks_pkg::tks_afe_t afe,
   output logic [63:0] sense_pin_en,
   // Events
   output logic scan_irq,
   output logic wake_req
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic scan_go;
   logic [6:0] cfg_a;
   logic [6:0] cfg_b;
   logic [6:0] chan_cfg;
   logic irq_en;
   logic scan_done;
   logic [5:0] analog_block_switches;
   logic [31:0] pin_lo;
   logic [31:0] pin_hi;
   logic [7:0] pullup_code;
   logic [15:0] scan_count_result;
   tks_pkg::tks_state_t state;
   logic [9:0] tcnt;
   logic [16:0] win;
   logic [15:0] raw;
   logic [2:0] ds_cnt;
   logic cmp_s1;
   logic cmp_s2;

   // ----------------------------------------
   // Decode and derived values
   // ----------------------------------------
   logic enabled;
   logic busy;
   logic wr_trig;
   logic wr_irq;
   logic start;
   logic abort;
   logic [2:0] counter_width_sel;
   logic [1:0] count_clock_sel;
   logic [15:0] width_mask;
   logic [2:0] ds_last;
   logic count_tick;
   logic [9:0] dis_cyc;
   logic [9:0] chg_cyc;
   logic sw_clk;

   assign enabled = touch_clock_gate && !touch_power_down;
   assign busy = state != tks_pkg::ST_IDLE;
   assign wr_trig = wr_stb && addr == `TKS_OFF_TRIGGER;
   assign wr_irq = wr_stb && addr == `TKS_OFF_IRQ;
   assign start = wr_trig && wdata[`TKS_GO_BIT] && !scan_go && enabled;
   assign abort = (wr_trig && !wdata[`TKS_GO_BIT] && busy) || !enabled;
   assign counter_width_sel = cfg_b[`TKS_WIDTH_LSB +: 3];
   assign count_clock_sel = cfg_b[`TKS_DS_LSB +: 2];
   assign width_mask = 16'((17'h1FFFF >> (3'd7 - counter_width_sel)) >> 1);
   assign dis_cyc = cfg_b[`TKS_PREDIS_BIT] ? 10'(`TKS_PREDIS_LONG_CYC)
                                           : 10'(`TKS_PREDIS_SHORT_CYC);
   assign chg_cyc = cfg_b[`TKS_PRECHG_BIT] ? 10'(`TKS_PRECHG_LONG_CYC)
                                           : 10'(`TKS_PRECHG_SHORT_CYC);

   // Count clock divide ratio: 25M every tick, 12.5M every 2, 6.25M every 4, about 4.17M every 6
   always_comb
   begin
      case (count_clock_sel)
         2'h0: ds_last = 3'h0;
         2'h1: ds_last = 3'h1;
         2'h2: ds_last = 3'h3;
         default: ds_last = 3'h5;
      endcase
   end
   assign count_tick = state == tks_pkg::ST_COUNT && ds_cnt == ds_last;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Configuration registers
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cfg_a <= `TKS_CFG_A_RST;
         cfg_b <= `TKS_CFG_B_RST;
         chan_cfg <= `TKS_CHAN_RST;
         irq_en <= 1'b0;
         analog_block_switches <= `TKS_ANA_RST;
         pin_lo <= 32'h00000000;
         pin_hi <= 32'h00000000;
         pullup_code <= `TKS_PULLUP_RST;
      end
      else if (wr_stb)
      begin
         if (addr == `TKS_OFF_CFG_A)
            cfg_a <= wdata[6:0];
         else if (addr == `TKS_OFF_CFG_B)
            cfg_b <= wdata[6:0];
         else if (addr == `TKS_OFF_CHAN)
            chan_cfg <= wdata[6:0];
         else if (addr == `TKS_OFF_IRQ)
            irq_en <= wdata[`TKS_IRQ_EN_BIT];
         else if (addr == `TKS_OFF_ANA)
            analog_block_switches <= wdata[5:0];
         else if (addr == `TKS_OFF_PIN_LO)
            pin_lo <= wdata;
         else if (addr == `TKS_OFF_PIN_HI)
            pin_hi <= wdata;
         else if (addr == `TKS_OFF_PULLUP)
            pullup_code <= wdata[7:0];
      end
   end

   // Go bit: software sets it, hardware clears it at the end of a scan
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         scan_go <= 1'b0;
      else if (state == tks_pkg::ST_DONE || abort)
         scan_go <= 1'b0;
      else if (start)
         scan_go <= 1'b1;
   end

   // Done flag: the set wins over a clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         scan_done <= 1'b0;
      else if (state == tks_pkg::ST_DONE)
         scan_done <= 1'b1;
      else if (wr_irq && wdata[`TKS_IRQ_CLR_BIT])
         scan_done <= 1'b0;
   end

   // ----------------------------------------
   // Register reads, answered one cycle later
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         rdata <= 32'h00000000;
      else if (rd_stb)
      begin
         if (addr == `TKS_OFF_TRIGGER)
            rdata <= {31'h0, scan_go};
         else if (addr == `TKS_OFF_CFG_A)
            rdata <= {25'h0, cfg_a};
         else if (addr == `TKS_OFF_CFG_B)
            rdata <= {25'h0, cfg_b};
         else if (addr == `TKS_OFF_CHAN)
            rdata <= {25'h0, chan_cfg};
         else if (addr == `TKS_OFF_IRQ)
            rdata <= {30'h0, scan_done, irq_en}; // Clear bit reads 0
         else if (addr == `TKS_OFF_ANA)
            rdata <= {26'h0, analog_block_switches};
         else if (addr == `TKS_OFF_PIN_LO)
            rdata <= pin_lo;
         else if (addr == `TKS_OFF_PIN_HI)
            rdata <= pin_hi;
         else if (addr == `TKS_OFF_PULLUP)
            rdata <= {24'h0, pullup_code};
         else if (addr == `TKS_OFF_RESULT)
            rdata <= {16'h0, scan_count_result};
         else
            rdata <= 32'h00000000; // Unmapped reads as zero
      end
   end

   // ----------------------------------------
   // Comparator synchroniser
   // ----------------------------------------
   // The pad comparator is asynchronous to the core clock
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
      end
      else
      begin
         cmp_s1 <= pad_cmp;
         cmp_s2 <= cmp_s1;
      end
   end

   // ----------------------------------------
   // Scan sequencer
   // ----------------------------------------
   // Phase order: pre-discharge, pre-charge, counting window, done
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || abort)
      begin
         state <= tks_pkg::ST_IDLE;
         tcnt <= 10'h000;
      end
      else
      begin
         case (state)
            tks_pkg::ST_IDLE:
               if (start)
                  state <= tks_pkg::ST_PRE_DIS;
            tks_pkg::ST_PRE_DIS:
               if (tcnt == dis_cyc - 10'h001)
               begin
                  tcnt <= 10'h000;
                  state <= tks_pkg::ST_PRE_CHG;
               end
               else
                  tcnt <= tcnt + 10'h001;
            tks_pkg::ST_PRE_CHG:
               if (tcnt == chg_cyc - 10'h001)
               begin
                  tcnt <= 10'h000;
                  state <= tks_pkg::ST_COUNT;
               end
               else
                  tcnt <= tcnt + 10'h001;
            tks_pkg::ST_COUNT:
               if (count_tick && win[15:0] == width_mask)
                  state <= tks_pkg::ST_DONE;
            default:
               state <= tks_pkg::ST_IDLE;
         endcase
      end
   end

   // Count clock divider, restarted at every scan
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || state != tks_pkg::ST_COUNT || ds_cnt == ds_last)
         ds_cnt <= 3'h0;
      else
         ds_cnt <= ds_cnt + 3'h1;
   end

   // Window and raw counters; window length is 2^(width+9) count ticks
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || state != tks_pkg::ST_COUNT)
      begin
         win <= 17'h00000;
         raw <= 16'h0000;
      end
      else if (count_tick)
      begin
         win <= win + 17'h00001;
         raw <= raw + {15'h0, cmp_s2};
      end
   end

   // Result is stored one cycle before the flag rises
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         scan_count_result <= 16'h0000;
      else if (state == tks_pkg::ST_COUNT && count_tick && win[15:0] == width_mask)
         scan_count_result <= (raw + {15'h0, cmp_s2}) & width_mask;
   end

   // ----------------------------------------
   // Front end and outputs
   // ----------------------------------------
   tks_charge_clk u_charge_clk
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(state == tks_pkg::ST_COUNT && !cfg_a[`TKS_SW_OFF_BIT]),
      .div_code(cfg_a[5:0]),
      .sw_clk(sw_clk),
      .sw_edge()
   );

   // Registered analog controls; current source in 0.5 steps
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         afe <= '0;
         sense_pin_en <= 64'h0;
      end
      else
      begin
         afe.sw_clk <= sw_clk;
         afe.discharge <= state == tks_pkg::ST_PRE_DIS;
         afe.precharge <= state == tks_pkg::ST_PRE_CHG;
         afe.parallel <= chan_cfg[`TKS_PAR_BIT];
         afe.chan <= chan_cfg[5:0];
         afe.pullup_half_ua <= `TKS_PULLUP_TOP - {1'b0, pullup_code};
         afe.res_sel <= analog_block_switches[`TKS_RES_LSB +: 2];
         afe.threshold_level_sel <= analog_block_switches[`TKS_VTH_LSB +: 3];
         sense_pin_en <= enabled ? {pin_hi, pin_lo} : 64'h0;
      end
   end

   assign scan_irq = scan_done && irq_en;
   assign wake_req = scan_done;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   result_then_flag_a: assert property ($rose(scan_done) |-> $past(state == tks_pkg::ST_DONE) && !scan_go && $past(scan_count_result, 1) == scan_count_result)
      else $error("flag rose without done phase");
   start_edge_a: assert property (start && !abort |=> state == tks_pkg::ST_PRE_DIS && scan_go)
      else $error("start write did not begin scan");
   abort_stop_a: assert property (wr_trig && !wdata[0] && busy |=> state == tks_pkg::ST_IDLE && !scan_go)
      else $error("abort did not stop scan");
   width_mask_a: assert property (state == tks_pkg::ST_DONE |->
      (scan_count_result & ~width_mask) == 16'h0)
      else $error("result exceeds counter width");
   predis_len_a: assert property ($rose(state == tks_pkg::ST_PRE_DIS) && !cfg_b[0] ##1 (state == tks_pkg::ST_PRE_DIS)[*8] |-> ##[41:42] state != tks_pkg::ST_PRE_DIS)
      else $error("pre-discharge length wrong");
   clear_flag_a: assert property (wr_irq && wdata[2] && state != tks_pkg::ST_DONE |=> !scan_done)
      else $error("done flag not cleared");
   gate_off_a: assert property (!touch_clock_gate || touch_power_down |=> state == tks_pkg::ST_IDLE)
      else $error("block ran while off");
   pullup_map_a: assert property (1'b1 |=>
      afe.pullup_half_ua == 9'h1FF - {1'b0, $past(pullup_code)})
      else $error("pull-up current code wrong");
   wake_irq_a: assert property (scan_done && irq_en |-> scan_irq && wake_req)
      else $error("completion not signalled");
   scan_done_c: cover property (state == tks_pkg::ST_DONE);
   scan_abort_c: cover property (state == tks_pkg::ST_COUNT && wr_trig && !wdata[0]);
   parallel_done_c: cover property (state == tks_pkg::ST_DONE && chan_cfg[6]);
endmodule : tks_scanner

// [bench/tks_pad_model.sv]
// Behavioural touch pad and comparator seen by the scanner's front end
module tks_pad_model
(
   // Clock
   input wire logic core_clk,
   // Front end from the scanner
   input wire tks_pkg::tks_afe_t afe,
   input wire logic [63:0] sense_pin_en,
   // Bench control: a slow pad needs more charge time before it trips
   input wire logic slow,
   // Comparator
   output logic pad_cmp
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] level = 4'h0;
   logic joined;
   // Parallel mode ties every enabled pin onto one node; otherwise only the addressed pin
   assign joined = afe.parallel ? (|sense_pin_en) : sense_pin_en[afe.chan];
   // Pad charges in the high phase, drains in the low phase and while pre-discharging
   always @(posedge core_clk)
   begin
      if (afe.discharge || !afe.sw_clk || !joined)
         level <= 4'h0;
      else if (level != 4'hF)
         level <= level + 4'h1;
   end
   // A pad with no enabled pin never charges, so the comparator stays low
   assign pad_cmp = (level >= (slow ? 4'h3 : 4'h1));
endmodule : tks_pad_model

// [bench/tb.sv]
// Self-checking testbench for the touch-key scan controller
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [31:0] rdata;
   logic touch_clock_gate = 1'b0;
   logic touch_power_down = 1'b0;
   logic pad_cmp;
   logic slow = 1'b0;
   tks_pkg::tks_afe_t afe;
   logic [63:0] sense_pin_en;
   logic scan_irq;
   logic wake_req;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h5A;
   logic [31:0] rv;
   logic [31:0] pins;
   int cyc;
   int exp_cyc;
   int k;
   int j;
   logic [31:0] res_q [$];
   // Reset image by word offset; the last slot is an unmapped address
   logic [31:0] exp_reg [0:10] = '{32'h0, 32'h0, 32'h70, 32'h0, 32'h0, 32'h20,
                                  32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   int sw [0:4] = '{0, 1, 0, 2, 7};
   int sds [0:4] = '{0, 1, 3, 2, 0};
   int spre [0:4] = '{0, 3, 1, 2, 0};
   int dv [0:3] = '{1, 2, 4, 6};
   int dcode [0:4] = '{0, 7, 61, 62, 63};

   always #20 core_clk = ~core_clk;

   tks_scanner i_tks_scanner (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .touch_clock_gate(touch_clock_gate),
      .touch_power_down(touch_power_down), .pad_cmp(pad_cmp), .afe(afe),
      .sense_pin_en(sense_pin_en), .scan_irq(scan_irq), .wake_req(wake_req));
   tks_pad_model i_tks_pad_model (.core_clk(core_clk), .afe(afe), .sense_pin_en(sense_pin_en),
      .slow(slow), .pad_cmp(pad_cmp));

   // ----------------------------------------
   // Bus, compare and wait helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   // Range compare; an unknown never lands inside the range
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         $display("[FAIL] t=%0t got=%h lo=%h", $time, got, lo);
         fail_count++;
      end
   endtask : chk_rng

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // Read data loads on the edge after the strobe and holds until the next read, so sample just past that edge
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rdchk

   // Bounded wait for the done flag; running out ends the run
   task automatic wait_done(input int lim);
      cyc = 0;
      while (wake_req !== 1'b1 && cyc < lim)
      begin
         @(posedge core_clk);
         #1;
         cyc++;
      end
      if (cyc >= lim)
      begin
         $display("[FAIL] t=%0t done wait=%h limit=%h", $time, cyc, lim);
         fail_count++;
         give_verdict();
      end
   endtask : wait_done

   // Cycles until the charge clock next toggles
   task automatic half_period();
      logic t0;
      cyc = 0;
      t0 = afe.sw_clk;
      while (afe.sw_clk === t0 && cyc < 2000)
      begin
         @(posedge core_clk);
         #1;
         cyc++;
      end
      if (cyc >= 2000)
      begin
         $display("[FAIL] t=%0t charge wait=%h limit=%h", $time, cyc, 2000);
         fail_count++;
         give_verdict();
      end
   endtask : half_period

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      touch_clock_gate <= 1'b1;
      wr(6'h24, 32'hFFFF);
      for (k = 0; k <= 10; k++)
         rdchk(6'(k * 4), exp_reg[k]);
      chk(32'(afe.pullup_half_ua), 32'h1FF);
      $display("test reset values done");
      // Field routing to the front end
      wr(6'h0C, 32'h7B);
      rdchk(6'h0C, 32'h7B);
      chk({25'h0, afe.parallel, afe.chan}, 32'h7B);
      for (k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         rv = (k == 0) ? 32'hFF : {24'h0, seed[7:0]};
         wr(6'h20, rv);
         @(posedge core_clk);
         #1;
         chk(32'(afe.pullup_half_ua), 32'h1FF - rv);
      end
      wr(6'h14, 32'h35);
      @(posedge core_clk);
      #1;
      chk({26'h0, afe.res_sel, 1'b0, afe.threshold_level_sel}, 32'h35);
      seed = xs(seed);
      pins = seed | 32'h1;
      wr(6'h18, pins);
      wr(6'h1C, ~pins);
      @(posedge core_clk);
      #1;
      chk(sense_pin_en[31:0], pins);
      chk(sense_pin_en[63:32], ~pins);
      $display("test fields done");
      // Full scans over width, count clock and pre-phase codes
      wr(6'h04, 32'd20);
      wr(6'h10, 32'h1);
      for (k = 0; k < 5; k++)
      begin
         slow <= (k == 3);
         wr(6'h08, 32'((sw[k] << 4) | (sds[k] << 2) | spre[k]));
         exp_cyc = (spre[k] % 2 ? 250 : 50) + (spre[k] / 2 ? 1000 : 500);
         exp_cyc = exp_cyc + (512 << sw[k]) * dv[sds[k]];
         wr(6'h00, 32'h1);
         rdchk(6'h00, 32'h1);
         wr(6'h00, 32'h1);
         wait_done(80000);
         chk_rng(cyc + 4, exp_cyc - 2, exp_cyc + 8);
         rdchk(6'h00, 32'h0);
         rdchk(6'h10, 32'h3);
         chk(scan_irq, 1'b1);
         rd(6'h24, rv);
         chk(rv >> (sw[k] + 9), 32'h0);
         chk_rng(rv, 32'h1, 32'((512 << sw[k]) - 1));
         res_q.push_back(rv);
         wr(6'h10, 32'h1);
         rdchk(6'h10, 32'h3);
         wr(6'h10, 32'h5);
         rdchk(6'h10, 32'h1);
         chk(scan_irq, 1'b0);
         rdchk(6'h24, res_q[$]);
      end
      $display("test scans done");
      // Dead pad with the interrupt masked: zero count, wake still flagged
      wr(6'h10, 32'h0);
      wr(6'h18, 32'h0);
      wr(6'h1C, 32'h0);
      wr(6'h08, 32'h0);
      wr(6'h00, 32'h1);
      wait_done(3000);
      chk(scan_irq, 1'b0);
      chk(wake_req, 1'b1);
      rdchk(6'h24, 32'h0);
      wr(6'h10, 32'h4);
      res_q.push_back(32'h0);
      $display("test dead pad done");
      // Charge clock periods, each scan aborted by software
      for (k = 0; k < 5; k++)
      begin
         wr(6'h04, 32'(dcode[k]));
         wr(6'h00, 32'h1);
         half_period();
         for (j = 0; j < 3; j++)
         begin
            half_period();
            if (dcode[k] < 62)
               chk(cyc, dcode[k] + 4);
            else
               chk_rng(cyc, 32'd8, 32'd23);
         end
         wr(6'h00, 32'h0);
         rdchk(6'h00, 32'h0);
         chk({afe.discharge, afe.precharge}, 32'h0);
         rdchk(6'h10, 32'h0);
         rdchk(6'h24, res_q[$]);
      end
      $display("test charge clock done");
      // Gate off refuses a start; power-down stops a running scan
      wr(6'h18, pins);
      @(posedge core_clk);
      touch_clock_gate <= 1'b0;
      wr(6'h00, 32'h1);
      rdchk(6'h00, 32'h0);
      chk(sense_pin_en[31:0], 32'h0);
      touch_clock_gate <= 1'b1;
      wr(6'h00, 32'h1);
      repeat (100) @(posedge core_clk);
      touch_power_down <= 1'b1;
      repeat (2) @(posedge core_clk);
      rdchk(6'h00, 32'h0);
      rdchk(6'h10, 32'h0);
      touch_power_down <= 1'b0;
      $display("test gate and power-down done");
      give_verdict();
   end
endmodule : tb
